// file: hw/gpio_port_pkg.sv
// Package with register map, reset values and carrier types of the GPIO port block.
`default_nettype none
package gpio_port_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] PORT_A_PIN_LEVEL = 8'h00;
   localparam logic [7:0] PORT_A_DIRECTION = 8'h01;
   localparam logic [7:0] PORT_B_PIN_LEVEL = 8'h03;
   localparam logic [7:0] PORT_B_DIRECTION = 8'h04;
   localparam logic [7:0] PORT_B_OUTPUT_LATCH = 8'h05;
   localparam logic [7:0] PORT_C_PIN_LEVEL = 8'h06;
   localparam logic [7:0] PORT_C_DIRECTION = 8'h07;
   localparam logic [7:0] PORT_C_OUTPUT_LATCH = 8'h08;
   localparam logic [7:0] PORT_D_PIN_LEVEL = 8'h09;
   localparam logic [7:0] PORT_D_DIRECTION = 8'h0A;
   localparam logic [7:0] PORT_D_OUTPUT_LATCH = 8'h0B;
   localparam logic [7:0] PORT_E_DIRECTION = 8'h0D;
   localparam logic [7:0] PORT_E_OUTPUT_LATCH = 8'h0E;
   localparam logic [7:0] PORT_A_OUTPUT_LATCH = 8'h22;
   localparam logic [7:0] CORE_CONTROL_BITS = 8'h35;
   // Block-local registers for the port J pin-change gating and the event interrupt.
   localparam logic [7:0] PIN_CHANGE_MASK = 8'h40;
   localparam logic [7:0] PIN_CHANGE_CONTROL = 8'h41;
   localparam logic [7:0] IRQ_STATUS = 8'h42;
   localparam logic [7:0] IRQ_CLEAR = 8'h43;
   localparam logic [7:0] IRQ_ENABLE = 8'h44;
   // Core control bit positions and writable mask.
   localparam int unsigned PULLUP_DISABLE_BIT = 4;
   localparam logic [7:0] CORE_CONTROL_WMASK = 8'h93;
   localparam logic [7:0] CORE_CONTROL_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] DIRECTION_RESET = 8'h00;
   localparam logic [6:0] MASK_RESET = 7'h00;
   localparam logic [6:0] IRQ_RESET = 7'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;
   // Port J pins carrying pin-change sources; pin 7 has none.
   localparam int unsigned PJ_SOURCES = 7;

   typedef struct packed {
      logic [7:0] latch;
      logic [7:0] direction;
   } port_cfg_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic [4:0][7:0] latch;
      logic [4:0][7:0] direction;
      logic [7:0] core_control;
      logic [6:0] pc_mask;
      logic pc_group_enable;
      logic [6:0] irq_status;
      logic [6:0] irq_enable;
      logic [3:0][7:0] sync1;
      logic [3:0][7:0] sync2;
      logic [7:0] pj_sync1;
      logic [7:0] pj_sync2;
      logic [7:0] pj_prev;
      logic [7:0] rdata;
   } gpio_state_t;
endpackage
`default_nettype wire

// file: hw/gpio_port.sv
// GPIO ports A to E with pull-up control and port J pin-change input gating.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module gpio_port #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic SYS_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [7:0] RDATA_OUT,
   output logic IRQ_OUT,
   input wire logic [39:0] PIN_IN,
   output logic [39:0] PIN_OUT,
   output logic [39:0] PIN_OE_OUT,
   output logic [39:0] PULLUP_OUT,
   input wire logic [7:0] PJ_PIN_IN,
   output logic [7:0] PJ_INPUT_ENABLE_OUT,
   output logic [6:0] PIN_CHANGE_SOURCE_OUT
);
   gpio_port_pkg::gpio_state_t state;
   gpio_port_pkg::gpio_state_t next_state;
   gpio_port_pkg::bus_req_t req;
   logic [7:0] input_enable_override_enable;
   logic [6:0] pj_change;
   logic pullups_on;

   // Masked write keeps the read-only bits at their current value.
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
                                        input logic [7:0] wmask);
      merge = (old & ~wmask) | (val & wmask);
   endfunction

   // Pull-ups of one 8-bit port from its latch and direction, gated by the enable.
   function automatic logic [7:0] pullup_of(input gpio_port_pkg::port_cfg_t cfg,
                                            input logic enable);
      pullup_of = enable ? (cfg.latch & ~cfg.direction) : 8'h00;
   endfunction

   assign req = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};
   assign pullups_on = ~state.core_control[gpio_port_pkg::PULLUP_DISABLE_BIT];

   // Port J overrides: only the input enable override may ever be asserted.
   always_comb begin
      input_enable_override_enable = 8'h00;
      if (LARGE_VARIANT) begin
         input_enable_override_enable[6:0] = state.pc_mask & {7{state.pc_group_enable}};
      end
   end

   // Input buffer is forced off (value 0) where the override is enabled.
   assign PJ_INPUT_ENABLE_OUT = LARGE_VARIANT ? ~input_enable_override_enable : 8'h00;
   assign pj_change = (state.pj_sync2[6:0] ^ state.pj_prev[6:0]) & state.pc_mask;
   assign PIN_CHANGE_SOURCE_OUT = LARGE_VARIANT ? state.pj_sync2[6:0] : 7'h00;

   // Pad drivers follow the port registers directly; port J never overrides them.
   always_comb begin
      for (int p = 0; p < 5; p++) begin
         PIN_OUT[p*8 +: 8] = state.latch[p] & state.direction[p];
         PIN_OE_OUT[p*8 +: 8] = state.direction[p];
         PULLUP_OUT[p*8 +: 8] = pullup_of('{latch: state.latch[p],
            direction: state.direction[p]}, pullups_on);
      end
   end

   assign RDATA_OUT = state.rdata;
   assign IRQ_OUT = |(state.irq_status & state.irq_enable);

   // Next-state logic: synchronisers, register writes, read mux and events.
   always_comb begin
      logic [6:0] irq_clear;
      irq_clear = 7'h00;
      next_state = state;
      next_state.sync1 = PIN_IN[31:0];
      next_state.sync2 = state.sync1;
      next_state.pj_sync1 = LARGE_VARIANT ? PJ_PIN_IN : 8'h00;
      next_state.pj_sync2 = state.pj_sync1;
      next_state.pj_prev = state.pj_sync2;
      next_state.rdata = gpio_port_pkg::READ_ZERO;
      if (req.wr) begin
         case (req.addr)
            gpio_port_pkg::PORT_A_OUTPUT_LATCH: next_state.latch[0] = req.wdata;
            gpio_port_pkg::PORT_B_OUTPUT_LATCH: next_state.latch[1] = req.wdata;
            gpio_port_pkg::PORT_C_OUTPUT_LATCH: next_state.latch[2] = req.wdata;
            gpio_port_pkg::PORT_D_OUTPUT_LATCH: next_state.latch[3] = req.wdata;
            gpio_port_pkg::PORT_E_OUTPUT_LATCH: next_state.latch[4] = req.wdata;
            gpio_port_pkg::PORT_A_DIRECTION: next_state.direction[0] = req.wdata;
            gpio_port_pkg::PORT_B_DIRECTION: next_state.direction[1] = req.wdata;
            gpio_port_pkg::PORT_C_DIRECTION: next_state.direction[2] = req.wdata;
            gpio_port_pkg::PORT_D_DIRECTION: next_state.direction[3] = req.wdata;
            gpio_port_pkg::PORT_E_DIRECTION: next_state.direction[4] = req.wdata;
            gpio_port_pkg::CORE_CONTROL_BITS: begin
               next_state.core_control = merge(state.core_control, req.wdata,
                  gpio_port_pkg::CORE_CONTROL_WMASK);
            end
            gpio_port_pkg::PIN_CHANGE_MASK: next_state.pc_mask = req.wdata[6:0];
            gpio_port_pkg::PIN_CHANGE_CONTROL: next_state.pc_group_enable = req.wdata[0];
            gpio_port_pkg::IRQ_CLEAR: irq_clear = req.wdata[6:0];
            gpio_port_pkg::IRQ_ENABLE: next_state.irq_enable = req.wdata[6:0];
            default: ;
         endcase
      end
      // Pin-level writes are accepted but have no effect here, so they read back pins.
      if (req.rd) begin
         case (req.addr)
            gpio_port_pkg::PORT_A_PIN_LEVEL: next_state.rdata = state.sync2[0];
            gpio_port_pkg::PORT_B_PIN_LEVEL: next_state.rdata = state.sync2[1];
            gpio_port_pkg::PORT_C_PIN_LEVEL: next_state.rdata = state.sync2[2];
            gpio_port_pkg::PORT_D_PIN_LEVEL: next_state.rdata = state.sync2[3];
            gpio_port_pkg::PORT_A_OUTPUT_LATCH: next_state.rdata = state.latch[0];
            gpio_port_pkg::PORT_B_OUTPUT_LATCH: next_state.rdata = state.latch[1];
            gpio_port_pkg::PORT_C_OUTPUT_LATCH: next_state.rdata = state.latch[2];
            gpio_port_pkg::PORT_D_OUTPUT_LATCH: next_state.rdata = state.latch[3];
            gpio_port_pkg::PORT_E_OUTPUT_LATCH: next_state.rdata = state.latch[4];
            gpio_port_pkg::PORT_A_DIRECTION: next_state.rdata = state.direction[0];
            gpio_port_pkg::PORT_B_DIRECTION: next_state.rdata = state.direction[1];
            gpio_port_pkg::PORT_C_DIRECTION: next_state.rdata = state.direction[2];
            gpio_port_pkg::PORT_D_DIRECTION: next_state.rdata = state.direction[3];
            gpio_port_pkg::PORT_E_DIRECTION: next_state.rdata = state.direction[4];
            gpio_port_pkg::CORE_CONTROL_BITS: next_state.rdata = state.core_control;
            gpio_port_pkg::PIN_CHANGE_MASK: next_state.rdata = {1'b0, state.pc_mask};
            gpio_port_pkg::PIN_CHANGE_CONTROL: next_state.rdata = {7'h00, state.pc_group_enable};
            gpio_port_pkg::IRQ_STATUS: next_state.rdata = {1'b0, state.irq_status};
            gpio_port_pkg::IRQ_ENABLE: next_state.rdata = {1'b0, state.irq_enable};
            default: next_state.rdata = gpio_port_pkg::READ_ZERO;
         endcase
      end
      // A new change in the clear cycle wins, so no event is lost.
      next_state.irq_status = (state.irq_status & ~irq_clear) | pj_change;
   end

   // Pin synchronisers take no reset value that matters; they reset to zero anyway.
   always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         state <= '0;
         state.core_control <= gpio_port_pkg::CORE_CONTROL_RESET;
         state.latch <= {5{gpio_port_pkg::LATCH_RESET}};
         state.direction <= {5{gpio_port_pkg::DIRECTION_RESET}};
         state.pc_mask <= gpio_port_pkg::MASK_RESET;
         state.irq_status <= gpio_port_pkg::IRQ_RESET;
         state.irq_enable <= gpio_port_pkg::IRQ_RESET;
      end else begin
         state <= next_state;
      end
   end
endmodule
`default_nettype wire

// file: verification/gpio_port_checker.sv
// Concurrent checks on the ports of the GPIO port block.
`timescale 1ns/10ps
`default_nettype none
module gpio_port_checker #(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic SYS_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic [7:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [7:0] RDATA_OUT,
   input wire logic IRQ_OUT,
   input wire logic [39:0] PIN_OUT,
   input wire logic [39:0] PIN_OE_OUT,
   input wire logic [39:0] PULLUP_OUT,
   input wire logic [7:0] PJ_INPUT_ENABLE_OUT,
   input wire logic [6:0] PIN_CHANGE_SOURCE_OUT
);
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // Pads only drive and pull where the direction bits allow it.
   drive_only_a: assert property ((PIN_OUT & ~PIN_OE_OUT) == 40'h0) else $error("pin driven as input");
   pull_input_a: assert property ((PULLUP_OUT & PIN_OE_OUT) == 40'h0) else $error("pull-up on output");
   pud_off_a: assert property (WR_IN && ADDR_IN == 8'h35 && WDATA_IN[4] |=> PULLUP_OUT == 40'h0) else $error("pull-up not disabled");
   // Read data stands one cycle only, and read-only core bits read zero.
   rd_idle_a: assert property (!RD_IN |=> RDATA_OUT == 8'h00) else $error("stray read data");
   core_ro_a: assert property (RD_IN && ADDR_IN == 8'h35 |=> (RDATA_OUT & 8'h6C) == 8'h00) else $error("core read-only bit set");
   dir_write_a: assert property (WR_IN && ADDR_IN == 8'h01 |=> PIN_OE_OUT[7:0] == $past(WDATA_IN)) else $error("direction not written");
   latch_write_a: assert property (WR_IN && ADDR_IN == 8'h22 |=> PIN_OUT[7:0] == ($past(WDATA_IN) & PIN_OE_OUT[7:0])) else $error("latch not written");
   pj7_plain_a: assert property (PJ_INPUT_ENABLE_OUT[7] == LARGE_VARIANT) else $error("pin 7 overridden");
   // Main scenarios.
   cover property (WR_IN && ADDR_IN == 8'h35 && WDATA_IN[4]);
   cover property ($rose(IRQ_OUT));
   cover property ($changed(PIN_CHANGE_SOURCE_OUT));
endmodule
`default_nettype wire

// file: verification/gpio_pad_model.sv
// Model of the pads and board around ports A to E.
`timescale 1ns/10ps
`default_nettype none
module gpio_pad_model (
   input wire logic clk_in,
   input wire logic [39:0] drive_in,
   input wire logic [39:0] oe_in,
   input wire logic [39:0] pullup_in,
   input wire logic [39:0] ext_in,
   input wire logic [39:0] ext_en_in,
   output logic [39:0] level_out
);
   bit [39:0] noise;
   // Floating pins flip every cycle, so a stale or unknown read never passes.
   always @(posedge clk_in) noise <= ~noise;
   // Output drive wins; otherwise the board level, the pull-up or noise.
   assign level_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_in)
      | (~oe_in & ~ext_en_in & (pullup_in | noise));
endmodule
`default_nettype wire

// file: verification/gpio_port_bench.sv
// Self-checking bench for the GPIO port block and its pad model.
`timescale 1ns/10ps
`default_nettype none
module gpio_port_bench;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, irq;
   logic [7:0] addr = 8'h00, wdata = 8'h00, pj = 8'h00, rdata, pj_ie, v;
   logic [6:0] pcs;
   logic [39:0] pin_in, pin_out, pin_oe, pull, ext = 40'h0, ext_en = 40'h0;
   logic [7:0] small_ie;
   logic [6:0] small_pcs;
   logic [7:0] exp_q[$];
   logic [7:0] regs [11] = '{8'h01, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0D,
      8'h0E, 8'h22, 8'h35};
   logic [7:0] val [11];
   int miscompares = 0, cmp_count = 0, seed = 32'h9A2E151B, i;
   gpio_port #(.LARGE_VARIANT(1'b1)) dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
      .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq),
      .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_OUT(pin_oe), .PULLUP_OUT(pull),
      .PJ_PIN_IN(pj), .PJ_INPUT_ENABLE_OUT(pj_ie), .PIN_CHANGE_SOURCE_OUT(pcs));
   gpio_pad_model pads (.clk_in(clk), .drive_in(pin_out), .oe_in(pin_oe), .pullup_in(pull),
      .ext_in(ext), .ext_en_in(ext_en), .level_out(pin_in));
   // Smaller variant sees the same bus and port J pins; its port J outputs must stay low.
   gpio_port #(.LARGE_VARIANT(1'b0)) dut_small (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
      .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(), .IRQ_OUT(),
      .PIN_IN(pin_in), .PIN_OUT(), .PIN_OE_OUT(), .PULLUP_OUT(), .PJ_PIN_IN(pj),
      .PJ_INPUT_ENABLE_OUT(small_ie), .PIN_CHANGE_SOURCE_OUT(small_pcs));
   initial forever #20 clk = ~clk;
   // Each bus task (wr_reg, rd_reg, idle) sets both strobes, so back-to-back calls never assign twice.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      wr <= 1'b0;
      exp_q.push_back(e);
      @(posedge clk);
   endtask
   task automatic idle;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t read got %h exp %h", $time, g, e);
      end
   endtask
   // Pin results are captured when the task is called; only the compare waits until mid-cycle.
   task automatic chk_pin(input logic [39:0] g, input logic [39:0] e);
      @(negedge clk);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t pins got %h exp %h", $time, g, e);
      end
      @(posedge clk);
   endtask
   task automatic wait_irq(input logic lvl);
      for (int n = 0; n < 8 && irq !== lvl; n++) @(negedge clk);
      chk_pin({39'h0, irq}, {39'h0, lvl});
      if (irq !== lvl) stop_test;
   endtask
   task automatic stop_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Read data is due in the cycle after the read strobe, compared to the oldest note.
   always @(posedge clk) rd_q <= rd;
   always @(negedge clk) begin
      if (rd_q) chk_rd(rdata, exp_q.pop_front());
   end
   // Main sequence: reset values, register access, pads, then port J events.
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 11; i++) rd_reg(regs[i], 8'h00);
      for (i = 0; i < 11; i++) begin
         val[i] = 8'($random(seed));
         wr_reg(regs[i], val[i]);
      end
      wr_reg(8'h50, 8'hFF);
      rd_reg(8'h50, 8'h00);
      for (i = 0; i < 11; i++) rd_reg(regs[i], i == 10 ? val[i] & 8'h93 : val[i]);
      v = 8'($random(seed));
      wr_reg(8'h22, v);
      wr_reg(8'h01, 8'h0F);
      wr_reg(8'h35, 8'h00);
      idle;
      chk_pin({24'h0, pull[7:0], pin_out[7:0]}, {24'h0, v & 8'hF0, v & 8'h0F});
      wr_reg(8'h35, 8'h10);
      idle;
      chk_pin(pull, 40'h0);
      v = 8'($random(seed));
      wr_reg(8'h04, 8'h00);
      ext[15:8] <= v;
      ext_en[15:8] <= 8'hFF;
      repeat (3) idle;
      rd_reg(8'h03, v);
      wr_reg(8'h40, 8'h55);
      wr_reg(8'h41, 8'h01);
      wr_reg(8'h44, 8'h7F);
      idle;
      chk_pin({32'h0, pj_ie}, {32'h0, 8'hAA});
      wr_reg(8'h41, 8'h00);
      idle;
      chk_pin({32'h0, pj_ie}, {32'h0, 8'hFF});
      pj[2] <= 1'b1;
      wait_irq(1'b1);
      chk_pin({33'h0, pcs}, 40'h4);
      chk_pin({25'h0, small_ie, small_pcs}, 40'h0);
      wr_reg(8'h44, 8'h00);
      idle;
      wait_irq(1'b0);
      wr_reg(8'h44, 8'h7F);
      rd_reg(8'h42, 8'h04);
      wr_reg(8'h43, 8'h04);
      idle;
      wait_irq(1'b0);
      pj[1] <= 1'b1;
      repeat (6) idle;
      rd_reg(8'h42, 8'h00);
      repeat (3) idle;
      stop_test;
   end
endmodule
bind gpio_port gpio_port_checker #(.LARGE_VARIANT(LARGE_VARIANT)) chk (.SYS_CLK_IN, .RST_N_IN,
   .ADDR_IN, .WDATA_IN, .WR_IN, .RD_IN, .RDATA_OUT, .IRQ_OUT, .PIN_OUT, .PIN_OE_OUT,
   .PULLUP_OUT, .PJ_INPUT_ENABLE_OUT, .PIN_CHANGE_SOURCE_OUT);
`default_nettype wire
